// File: umar_map.vh
// What this block does
// - nine-bit modes capture nine data bits, ninth into received_ninth_bit, then stop
// - modes 2/3 with filter set: no receive_flag when ninth bit is 0
// - mode 1 with filter set: receive_flag only after a valid stop bit
// - filter set, nine-bit modes: ninth bit 1 and address hit raise receive_flag
// - given address compares only bits where the mask is 1
// - broadcast address is value OR mask; its zero bits are don't-care
// - reset clears match value and mask, so every address hits
// - mode bits: 00 shift/16, 01 8-bit variable, 10 9-bit /32, 11 9-bit variable
// - reception only while receive_enable is set
// - modes 2/3 send transmit_ninth_bit live as ninth bit, not buffered
// - received_ninth_bit: ninth bit in modes 2/3, stop bit in mode 1 unfiltered
// - transmit_done_flag set when another byte may be written; only software clears
// - write to data buffer starts transmit; receive start rules per mode
// - nine-bit frame: start 0, eight data lsb first, ninth bit, stop 1
`ifndef UMAR_MAP_VH
`define UMAR_MAP_VH
// ==========================================================
// register offsets (byte addresses)
`define UMAR_OFS_CTRL0    12'h420
`define UMAR_OFS_CTRL1    12'h424
`define UMAR_OFS_DATA     12'h428
`define UMAR_OFS_MVAL     12'h42c
`define UMAR_OFS_MMSK     12'h430
`define UMAR_OFS_STAT     12'h434
// ==========================================================
// control register fields and reset values
`define UMAR_B_MODE_HI    7
`define UMAR_B_MODE_LO    6
`define UMAR_B_FILT       5
`define UMAR_B_RXEN       4
`define UMAR_B_TB8        3
`define UMAR_B_RB8        2
`define UMAR_B_TI         1
`define UMAR_B_RI         0
`define UMAR_CTRL_RST     8'h00
`define UMAR_MATCH_RST    8'h00
// ==========================================================
// modes
`define UMAR_MODE_SHIFT   2'h0
`define UMAR_MODE_8VAR    2'h1
`define UMAR_MODE_9FIX    2'h2
`define UMAR_MODE_9VAR    2'h3
// ==========================================================
// timing: ticks are sixteen per bit
`define UMAR_TICK_LAST    4'hf
`define UMAR_TICK_MID     4'h7
`define UMAR_BITS_SHIFT   4'h8
`define UMAR_BITS_8       4'ha
`define UMAR_BITS_9       4'hb
`define UMAR_IDX_NINTH    4'h9
`define UMAR_FIFO_DEPTH   16
`define UMAR_FIFO_AW      4
`endif

// File: umar_fifo.v
`timescale 1ns/100ps
`default_nettype none
module umar_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // clock and reset
   input  wire             i_clk,
   input  wire             i_rst_b,
   // fill side
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   // drain side
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data,
   // status
   output wire [AW:0]      o_count
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_reg;
   reg [AW-1:0]    rd_ptr_reg;
   reg [AW:0]      count_reg;
   wire            push;
   wire            pop;
   assign o_in_ready  = (count_reg != DEPTH[AW:0]);
   assign o_out_valid = (count_reg != {(AW+1){1'b0}});
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;
   assign o_out_data  = mem[rd_ptr_reg];
   assign o_count     = count_reg;
   // ==========================================================
   // storage has no reset; only the pointers and the count do
   always @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= i_in_data;
      end
   end
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push & ~pop) begin
            count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // umar_fifo
`default_nettype wire

// File: umar_top.v
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "umar_map.vh"
module umar_top (
   // clock and reset
   input  wire        I_CLK_SYS,
   input  wire        I_RST_B,
   // register port
   input  wire [11:0] I_ADDR,
   input  wire [7:0]  I_WDATA,
   input  wire        I_WR,
   input  wire        I_RD,
   output reg  [7:0]  O_RDATA,
   // baud source for modes 1 and 3, sixteen per bit
   input  wire        I_BAUD_TICK,
   // serial pins
   input  wire        I_RXD,
   output reg         O_RXD_OUT,
   output reg         O_RXD_OE,
   output reg         O_TXD
);
   // ==========================================================
   // states
   localparam RX_IDLE  = 3'h0;
   localparam RX_START = 3'h1;
   localparam RX_DATA  = 3'h2;
   localparam RX_STOP  = 3'h3;
   localparam RX_SHIFT = 3'h4;
   localparam TX_IDLE  = 1'b0;
   localparam TX_RUN   = 1'b1;

   // ==========================================================
   // address decode helpers
   function hit;
      input [7:0] rx_byte;
      input [7:0] ref_byte;
      input [7:0] care;
      begin
         hit = (((rx_byte ^ ref_byte) & care) == 8'h00);
      end
   endfunction

   reg  [7:0]  ctrl_reg;
   reg  [7:0]  ctrl_next;
   reg  [7:0]  mval_reg;
   reg  [7:0]  mmsk_reg;
   reg         div_reg;
   reg  [2:0]  rx_st_reg;
   reg  [2:0]  rx_st_next;
   reg  [3:0]  rx_tick_reg;
   reg  [3:0]  rx_tick_next;
   reg  [3:0]  rx_bit_reg;
   reg  [3:0]  rx_bit_next;
   reg  [8:0]  rx_sh_reg;
   reg  [8:0]  rx_sh_next;
   reg         rx_prev_reg;
   reg         tx_st_reg;
   reg         tx_st_next;
   reg  [3:0]  tx_tick_reg;
   reg  [3:0]  tx_tick_next;
   reg  [3:0]  tx_bit_reg;
   reg  [3:0]  tx_bit_next;
   reg  [7:0]  tx_sh_reg;
   reg  [7:0]  tx_sh_next;
   reg  [7:0]  hold_reg;
   reg         hold_full_reg;
   reg         hold_full_next;
   reg         set_ri;
   reg         set_ti;
   reg         ld_rb8;
   reg         rb8_val;
   reg         push;
   reg  [7:0]  push_data;
   reg         tx_bit;
   reg  [3:0]  tx_len;
   reg  [7:0]  rd_next;
   reg         sclk;

   wire [1:0]  mode;
   wire        nine;
   wire        filt;
   wire        rxen;
   wire        tick;
   wire        wr_ctrl;
   wire        wr_data;
   wire        rd_data;
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [7:0]  fifo_out_data;
   wire [4:0]  fifo_count;
   wire [7:0]  bcast;
   wire        addr_ok;

   assign mode    = {ctrl_reg[`UMAR_B_MODE_HI], ctrl_reg[`UMAR_B_MODE_LO]};
   assign nine    = mode[1];
   assign filt    = ctrl_reg[`UMAR_B_FILT];
   assign rxen    = ctrl_reg[`UMAR_B_RXEN];
   assign wr_ctrl = I_WR & (I_ADDR == `UMAR_OFS_CTRL0);
   assign wr_data = I_WR & (I_ADDR == `UMAR_OFS_DATA);
   assign rd_data = I_RD & (I_ADDR == `UMAR_OFS_DATA);
   // ==========================================================
   // bit rate tick: mode 0 osc/16, mode 2 osc/32, else external
   assign tick = (mode == `UMAR_MODE_SHIFT) ? 1'b1 :
                 (mode == `UMAR_MODE_9FIX)  ? div_reg :
                 I_BAUD_TICK;
   // ==========================================================
   // address recognition
   assign bcast   = mval_reg | mmsk_reg;
   assign addr_ok = hit(rx_sh_reg[7:0], mval_reg, mmsk_reg) |
                    hit(rx_sh_reg[7:0], bcast, bcast);

   // ==========================================================
   // received byte queue; a full queue holds off the next frame
   umar_fifo #(
      .WIDTH (8),
      .DEPTH (`UMAR_FIFO_DEPTH),
      .AW    (`UMAR_FIFO_AW)
   ) u_fifo (
      .i_clk       (I_CLK_SYS),
      .i_rst_b     (I_RST_B),
      .i_in_valid  (push),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (push_data),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (rd_data),
      .o_out_data  (fifo_out_data),
      .o_count     (fifo_count)
   );

   // ==========================================================
   // receiver
   always @* begin
      rx_st_next   = rx_st_reg;
      rx_tick_next = rx_tick_reg;
      rx_bit_next  = rx_bit_reg;
      rx_sh_next   = rx_sh_reg;
      set_ri       = 1'b0;
      ld_rb8       = 1'b0;
      rb8_val      = 1'b0;
      push         = 1'b0;
      push_data    = rx_sh_reg[7:0];
      case (rx_st_reg)
         RX_IDLE: begin
            rx_tick_next = 4'h0;
            rx_bit_next  = 4'h0;
            if (rxen & fifo_in_ready) begin
               if (mode == `UMAR_MODE_SHIFT) begin
                  // mode 0 starts on flag clear, not on the line
                  if (~ctrl_reg[`UMAR_B_RI] & (tx_st_reg == TX_IDLE)) begin
                     rx_st_next = RX_SHIFT;
                  end
               end else if (rx_prev_reg & ~I_RXD) begin
                  rx_st_next = RX_START;
               end
            end
         end
         RX_START: begin
            if (tick) begin
               rx_tick_next = rx_tick_reg + 4'h1;
               if (rx_tick_reg == `UMAR_TICK_MID) begin
                  // glitch guard: start must still be low mid-bit
                  rx_st_next = I_RXD ? RX_IDLE : RX_START;
               end else if (rx_tick_reg == `UMAR_TICK_LAST) begin
                  rx_st_next = RX_DATA;
               end
            end
         end
         RX_DATA: begin
            if (tick) begin
               rx_tick_next = rx_tick_reg + 4'h1;
               if (rx_tick_reg == `UMAR_TICK_MID) begin
                  rx_sh_next  = {I_RXD, rx_sh_reg[8:1]};
                  rx_bit_next = rx_bit_reg + 4'h1;
               end else if (rx_tick_reg == `UMAR_TICK_LAST) begin
                  if (rx_bit_reg == (nine ? 4'h9 : 4'h8)) begin
                     rx_st_next = RX_STOP;
                  end
               end
            end
         end
         RX_STOP: begin
            if (tick) begin
               rx_tick_next = rx_tick_reg + 4'h1;
               if (rx_tick_reg == `UMAR_TICK_MID) begin
                  rx_st_next = RX_IDLE;
                  if (nine) begin
                     // the ninth bit sits at the top of the shifter
                     if (~filt | (rx_sh_reg[8] & addr_ok)) begin
                        set_ri    = 1'b1;
                        push      = 1'b1;
                        ld_rb8    = 1'b1;
                        rb8_val   = rx_sh_reg[8];
                     end
                  end else begin
                     push_data = rx_sh_reg[8:1];
                     if (~filt | I_RXD) begin
                        set_ri = 1'b1;
                        push   = 1'b1;
                        ld_rb8 = ~filt;
                        rb8_val = I_RXD;
                     end
                  end
               end
            end
         end
         RX_SHIFT: begin
            // filter bit is ignored here on purpose
            rx_tick_next = rx_tick_reg + 4'h1;
            if (rx_tick_reg == `UMAR_TICK_LAST) begin
               rx_sh_next  = {I_RXD, rx_sh_reg[8:1]};
               rx_bit_next = rx_bit_reg + 4'h1;
               if (rx_bit_reg == `UMAR_BITS_SHIFT - 4'h1) begin
                  rx_st_next = RX_IDLE;
                  set_ri     = 1'b1;
                  push       = 1'b1;
                  push_data  = {I_RXD, rx_sh_reg[8:2]};
               end
            end
         end
         default: begin
            rx_st_next = RX_IDLE;
         end
      endcase
      if (~rxen) begin
         rx_st_next = RX_IDLE;
      end
   end

   // ==========================================================
   // transmitter with one holding byte
   always @* begin
      case (mode)
         `UMAR_MODE_SHIFT: tx_len = `UMAR_BITS_SHIFT;
         `UMAR_MODE_8VAR:  tx_len = `UMAR_BITS_8;
         default:          tx_len = `UMAR_BITS_9;
      endcase
      if (mode == `UMAR_MODE_SHIFT) begin
         tx_bit = tx_sh_reg[0];
      end else if (tx_bit_reg == 4'h0) begin
         tx_bit = 1'b0;
      end else if (tx_bit_reg <= 4'h8) begin
         tx_bit = tx_sh_reg[0];
      end else if (nine & (tx_bit_reg == `UMAR_IDX_NINTH)) begin
         // taken live, so it must be right when it goes out
         tx_bit = ctrl_reg[`UMAR_B_TB8];
      end else begin
         tx_bit = 1'b1;
      end
   end

   always @* begin
      tx_st_next     = tx_st_reg;
      tx_tick_next   = tx_tick_reg;
      tx_bit_next    = tx_bit_reg;
      tx_sh_next     = tx_sh_reg;
      hold_full_next = hold_full_reg;
      set_ti         = 1'b0;
      if (wr_data) begin
         hold_full_next = 1'b1;
         // second buffer still free when the line is idle
         set_ti = (tx_st_reg == TX_IDLE);
      end
      case (tx_st_reg)
         TX_IDLE: begin
            if (hold_full_reg & (rx_st_reg != RX_SHIFT)) begin
               tx_st_next     = TX_RUN;
               tx_sh_next     = hold_reg;
               tx_tick_next   = 4'h0;
               tx_bit_next    = 4'h0;
               hold_full_next = wr_data;
            end
         end
         TX_RUN: begin
            if (tick) begin
               tx_tick_next = tx_tick_reg + 4'h1;
               if (tx_tick_reg == `UMAR_TICK_LAST) begin
                  tx_bit_next = tx_bit_reg + 4'h1;
                  if ((mode == `UMAR_MODE_SHIFT) |
                      ((tx_bit_reg != 4'h0) & (tx_bit_reg <= 4'h8))) begin
                     tx_sh_next = {1'b0, tx_sh_reg[7:1]};
                  end
                  if (tx_bit_reg == tx_len - 4'h1) begin
                     tx_st_next = TX_IDLE;
                     set_ti     = 1'b1;
                  end
               end
            end
         end
         default: begin
            tx_st_next = TX_IDLE;
         end
      endcase
   end

   // ==========================================================
   // control register; hardware sets win over software clears
   always @* begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = I_WDATA;
      end
      if (ld_rb8) begin
         ctrl_next[`UMAR_B_RB8] = rb8_val;
      end
      if (set_ri) begin
         ctrl_next[`UMAR_B_RI] = 1'b1;
      end
      if (set_ti) begin
         ctrl_next[`UMAR_B_TI] = 1'b1;
      end
   end

   // ==========================================================
   // read mux; a data read pops the queue
   always @* begin
      case (I_ADDR)
         `UMAR_OFS_CTRL0: rd_next = ctrl_reg;
         `UMAR_OFS_DATA:  rd_next = fifo_out_valid ? fifo_out_data : 8'h00;
         `UMAR_OFS_MVAL:  rd_next = mval_reg;
         `UMAR_OFS_MMSK:  rd_next = mmsk_reg;
         `UMAR_OFS_STAT:  rd_next = {hold_full_reg, tx_st_reg,
                                     (rx_st_reg != RX_IDLE), fifo_count};
         default:         rd_next = 8'h00;
      endcase
   end

   // ==========================================================
   // shift clock for mode 0: low first half, high second half
   always @* begin
      sclk = 1'b1;
      if ((mode == `UMAR_MODE_SHIFT) & (tx_st_reg == TX_RUN)) begin
         sclk = tx_tick_reg[3];
      end else if (rx_st_reg == RX_SHIFT) begin
         sclk = rx_tick_reg[3];
      end
   end

   // ==========================================================
   // flops
   always @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ctrl_reg      <= `UMAR_CTRL_RST;
         mval_reg      <= `UMAR_MATCH_RST;
         mmsk_reg      <= `UMAR_MATCH_RST;
         div_reg       <= 1'b0;
         rx_st_reg     <= RX_IDLE;
         rx_tick_reg   <= 4'h0;
         rx_bit_reg    <= 4'h0;
         rx_sh_reg     <= 9'h000;
         rx_prev_reg   <= 1'b1;
         tx_st_reg     <= TX_IDLE;
         tx_tick_reg   <= 4'h0;
         tx_bit_reg    <= 4'h0;
         tx_sh_reg     <= 8'h00;
         hold_reg      <= 8'h00;
         hold_full_reg <= 1'b0;
         O_RDATA       <= 8'h00;
         O_RXD_OUT     <= 1'b1;
         O_RXD_OE      <= 1'b0;
         O_TXD         <= 1'b1;
      end else begin
         ctrl_reg      <= ctrl_next;
         div_reg       <= ~div_reg;
         rx_st_reg     <= rx_st_next;
         rx_tick_reg   <= rx_tick_next;
         rx_bit_reg    <= rx_bit_next;
         rx_sh_reg     <= rx_sh_next;
         rx_prev_reg   <= I_RXD;
         tx_st_reg     <= tx_st_next;
         tx_tick_reg   <= tx_tick_next;
         tx_bit_reg    <= tx_bit_next;
         tx_sh_reg     <= tx_sh_next;
         hold_full_reg <= hold_full_next;
         if (wr_data) begin
            hold_reg <= I_WDATA;
         end
         if (I_WR & (I_ADDR == `UMAR_OFS_MVAL)) begin
            mval_reg <= I_WDATA;
         end
         if (I_WR & (I_ADDR == `UMAR_OFS_MMSK)) begin
            mmsk_reg <= I_WDATA;
         end
         O_RDATA <= I_RD ? rd_next : 8'h00;
         // mode 0 puts data on the receive pin, clock on transmit
         if (mode == `UMAR_MODE_SHIFT) begin
            O_TXD     <= sclk;
            O_RXD_OUT <= tx_bit;
            O_RXD_OE  <= (tx_st_reg == TX_RUN);
         end else begin
            O_TXD     <= (tx_st_reg == TX_RUN) ? tx_bit : 1'b1;
            O_RXD_OUT <= 1'b1;
            O_RXD_OE  <= 1'b0;
         end
      end
   end
endmodule // umar_top
`default_nettype wire

// File: umar_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "umar_map.vh"
// ==========================================================
// checker on the top ports
module umar_top_asserts (
   // clock and reset
   input wire logic        I_CLK_SYS,
   input wire logic        I_RST_B,
   // register port
   input wire logic [11:0] I_ADDR,
   input wire logic [7:0]  I_WDATA,
   input wire logic        I_WR,
   input wire logic        I_RD,
   input wire logic [7:0]  O_RDATA,
   // serial side
   input wire logic        I_BAUD_TICK,
   input wire logic        I_RXD,
   input wire logic        O_RXD_OUT,
   input wire logic        O_RXD_OE,
   input wire logic        O_TXD
);
   logic [7:0] ctl_reg;
   logic [1:0] flg_reg;
   logic [5:0] hi_reg;
   logic       mw_reg;
   logic       rdq_reg;
   logic       rsq_reg;
   wire logic  ctl_wr = I_WR && I_ADDR == `UMAR_OFS_CTRL0;
   // flags only fall on a control write: a lost set weakens, never misfires
   always @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ctl_reg <= 8'h00;
         flg_reg <= 2'h0;
         hi_reg  <= 6'h00;
         mw_reg  <= 1'b0;
         rdq_reg <= 1'b0;
         rsq_reg <= 1'b0;
      end else begin
         if (ctl_wr)
            ctl_reg <= I_WDATA;
         if (ctl_wr)
            flg_reg <= flg_reg & I_WDATA[1:0];
         else if (rdq_reg)
            flg_reg <= flg_reg | O_RDATA[1:0];
         if (I_WR && (I_ADDR == `UMAR_OFS_MVAL || I_ADDR == `UMAR_OFS_MMSK))
            mw_reg <= 1'b1;
         rdq_reg <= I_RD && I_ADDR == `UMAR_OFS_CTRL0;
         rsq_reg <= I_RD && I_ADDR == `UMAR_OFS_STAT;
         hi_reg  <= !O_TXD ? 6'h00 : hi_reg + {5'h00, hi_reg != 6'h3f};
      end
   end
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RST_B);
   property p_match_rst;
      I_RD && !mw_reg && (I_ADDR == `UMAR_OFS_MVAL ||
         I_ADDR == `UMAR_OFS_MMSK) |=> O_RDATA == 8'h00;
   endproperty
   a_match_rst: assert property (p_match_rst)
      else $error("match register not zero after reset");
   property p_bit_low;
      ctl_reg[7:6] == 2'h2 && $fell(O_TXD) |-> ##30 !O_TXD;
   endproperty
   a_bit_low: assert property (p_bit_low)
      else $error("low bit shorter than its time");
   property p_bit_high;
      ctl_reg[7:6] == 2'h2 && $rose(O_TXD) |=> O_TXD[*8] ##21 O_TXD;
   endproperty
   a_bit_high: assert property (p_bit_high)
      else $error("high bit shorter than its time");
   property p_stop;
      ctl_reg[7:6] == 2'h2 && hi_reg == 6'h3f && !O_TXD
         |-> ##300 ##28 O_TXD[*8];
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop bit missing in eleventh place");
   // pins are registered from the mode, so they follow it one cycle late
   property p_pin_idle;
      ctl_reg[7:6] != 2'h0 |=> !O_RXD_OE && O_RXD_OUT;
   endproperty
   a_pin_idle: assert property (p_pin_idle)
      else $error("receive pin driven outside shift mode");
   property p_sticky;
      rdq_reg && flg_reg != 2'h0 |-> (O_RDATA[1:0] & flg_reg) == flg_reg;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag cleared without software");
   property p_filter;
      rdq_reg && ctl_reg[7] && ctl_reg[5] && !ctl_reg[0] && O_RDATA[0]
         |-> O_RDATA[2];
   endproperty
   a_filter: assert property (p_filter)
      else $error("frame with ninth bit low accepted");
   property p_rxen;
      rsq_reg && !ctl_reg[4] && !$past(ctl_reg[4], 3) |-> !O_RDATA[5];
   endproperty
   a_rxen: assert property (p_rxen)
      else $error("receiver busy while disabled");
endmodule // umar_top_asserts
bind umar_top umar_top_asserts u_chk (
   .I_CLK_SYS   (I_CLK_SYS),
   .I_RST_B     (I_RST_B),
   .I_ADDR      (I_ADDR),
   .I_WDATA     (I_WDATA),
   .I_WR        (I_WR),
   .I_RD        (I_RD),
   .O_RDATA     (O_RDATA),
   .I_BAUD_TICK (I_BAUD_TICK),
   .I_RXD       (I_RXD),
   .O_RXD_OUT   (O_RXD_OUT),
   .O_RXD_OE    (O_RXD_OE),
   .O_TXD       (O_TXD)
);
`default_nettype wire

// File: umar_line_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// line master: one frame per request
module umar_line_model #(
   parameter int BIT_CLKS = 32
) (
   // clock
   input  wire logic        i_clk,
   // frame request
   input  wire logic        i_go,
   input  wire logic [10:0] i_frame,
   input  wire logic [3:0]  i_nbits,
   // line side
   output var  logic        o_rxd,
   output var  logic        o_busy
);
   initial begin
      o_rxd  = 1'b1;
      o_busy = 1'b0;
   end
   always @(posedge i_clk) begin
      if (i_go && !o_busy) begin
         o_busy <= 1'b1;
         for (int i = 0; i < i_nbits; i++) begin
            o_rxd <= i_frame[i];
            repeat (BIT_CLKS) @(posedge i_clk);
         end
         // pulled high between frames
         o_rxd  <= 1'b1;
         o_busy <= 1'b0;
      end
   end
endmodule // umar_line_model
`default_nettype wire

// File: umar_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "umar_map.vh"
module umar_bench;
   typedef struct packed {
      logic [1:0] md;
      logic       fl, en, n9, sp, ri, r8;
      logic [7:0] va, mk, by;
   } umar_row_t;
   // ==========================================================
   // rows: mode filt rxen ninth stop | ri rb8 | value mask byte
   // filter is never set in mode 0
   umar_row_t rows [10] = '{
      '{2'h2, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 8'h00, 8'h00, 8'h3c},
      '{2'h2, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 8'h3c},
      '{2'h2, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 8'hc0, 8'hfd, 8'hc2},
      '{2'h2, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 8'hc0, 8'hfd, 8'hc1},
      '{2'h3, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 8'hc0, 8'hfd, 8'hff},
      '{2'h3, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 8'h00, 8'h00, 8'h5a},
      '{2'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00, 8'h00, 8'h77},
      '{2'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 8'h00, 8'h00, 8'h77},
      '{2'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 8'h00, 8'h00, 8'h81},
      '{2'h2, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 8'h5a, 8'h3c, 8'h11}
   };
   logic        clk   = 1'b0;
   logic        rst_b = 1'b0;
   logic [11:0] addr  = 12'h000;
   logic [7:0]  wdata = 8'h00;
   logic        wr    = 1'b0;
   logic        rd    = 1'b0;
   logic        tick  = 1'b0;
   logic        go    = 1'b0;
   logic [10:0] frame = 11'h7ff;
   logic [3:0]  nbits = 4'hb;
   logic [7:0]  rdata;
   logic        rxd_out;
   logic        rxd_oe;
   logic        txd;
   logic        rxd;
   logic        busy;
   logic [10:0] cap;
   int          fail_count = 0;
   int          num_checks = 0;
   int          cyc = 0;
   wire logic   line = rxd_oe ? rxd_out : rxd;
   umar_top DUT (
      .I_CLK_SYS   (clk),
      .I_RST_B     (rst_b),
      .I_ADDR      (addr),
      .I_WDATA     (wdata),
      .I_WR        (wr),
      .I_RD        (rd),
      .O_RDATA     (rdata),
      .I_BAUD_TICK (tick),
      .I_RXD       (line),
      .O_RXD_OUT   (rxd_out),
      .O_RXD_OE    (rxd_oe),
      .O_TXD       (txd)
   );
   umar_line_model u_line (
      .i_clk   (clk),
      .i_go    (go),
      .i_frame (frame),
      .i_nbits (nbits),
      .o_rxd   (rxd),
      .o_busy  (busy)
   );
   always #20 clk = ~clk;
   // same bit time in modes 1 to 3 keeps one line model for all rows
   always @(posedge clk) tick <= ~tick;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // ==========================================================
   // tasks
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, e});
      @(posedge clk);
   endtask
   task automatic send(input logic [10:0] f, input logic [3:0] n);
      frame <= f;
      nbits <= n;
      go    <= 1'b1;
      @(posedge clk);
      go    <= 1'b0;
      @(posedge clk);
      while (busy)
         @(posedge clk);
      repeat (8) @(posedge clk);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      umar_row_t r;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         r = rows[i];
         wr_reg(`UMAR_OFS_CTRL0, {r.md, r.fl, r.en, 4'h0});
         wr_reg(`UMAR_OFS_MVAL, r.va);
         wr_reg(`UMAR_OFS_MMSK, r.mk);
         if (r.md == 2'h1)
            send({1'h1, r.sp, r.by, 1'h0}, 4'ha);
         else
            send({r.sp, r.n9, r.by, 1'h0}, 4'hb);
         rchk(`UMAR_OFS_CTRL0, {r.md, r.fl, r.en, 1'h0, r.r8, 1'h0, r.ri});
         rchk(`UMAR_OFS_DATA, r.ri ? r.by : 8'h00);
      end
      // reserved and unmapped places ignore writes
      wr_reg(12'h424, 8'hff);
      wr_reg(12'h7fc, 8'hff);
      rchk(12'h424, 8'h00);
      rchk(12'h7fc, 8'h00);
      rchk(`UMAR_OFS_MVAL, 8'h5a);
      // mode 0 shifts eight bits in off the idle-high line
      wr_reg(`UMAR_OFS_CTRL0, 8'h10);
      repeat (140) @(posedge clk);
      rchk(`UMAR_OFS_CTRL0, 8'h11);
      rchk(`UMAR_OFS_DATA, 8'hff);
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rchk(`UMAR_OFS_CTRL0, 8'h00);
      rchk(`UMAR_OFS_MVAL, 8'h00);
      rchk(`UMAR_OFS_MMSK, 8'h00);
      rchk(`UMAR_OFS_STAT, 8'h00);
      // ninth bit changed mid-frame, flag cleared mid-frame
      wr_reg(`UMAR_OFS_CTRL0, 8'h88);
      // a long idle line first, so the stop-bit check arms
      repeat (64) @(posedge clk);
      wr_reg(`UMAR_OFS_DATA, 8'ha5);
      for (int n = 0; txd && n < 64; n++)
         @(posedge clk);
      repeat (15) @(posedge clk);
      for (int b = 0; b < 11; b++) begin
         cap[b] = txd;
         if (b == 1)
            wr_reg(`UMAR_OFS_CTRL0, 8'h80);
         else
            repeat (2) @(posedge clk);
         repeat (30) @(posedge clk);
      end
      chk({5'h00, cap}, {5'h00, 11'h54a});
      rchk(`UMAR_OFS_CTRL0, 8'h82);
      // fill the queue past full while nobody drains it
      wr_reg(`UMAR_OFS_CTRL0, 8'h90);
      for (int k = 0; k < 17; k++)
         send({2'h3, k[7:0], 1'h0}, 4'hb);
      rchk(`UMAR_OFS_STAT, 8'h10);
      rchk(`UMAR_OFS_CTRL0, 8'h95);
      for (int k = 0; k < 16; k++)
         rchk(`UMAR_OFS_DATA, k[7:0]);
      rchk(`UMAR_OFS_STAT, 8'h00);
      rchk(`UMAR_OFS_DATA, 8'h00);
      rchk(`UMAR_OFS_CTRL0, 8'h95);
      report_and_stop();
   end
endmodule // umar_bench
`default_nettype wire
